// ===== rtl/mps_host_ctrl.sv
// SPI host controller for a single-pair Ethernet MAC-PHY: register, burst and chunk transfers
// Assumes a software port with one-cycle strobes and a device on the SPI pins in mode 0
//
// Summary of operation
// R1 - Device keeps 2-byte size with each frame
// R2 - Host reads FIFO space before loading frame
// R3 - Host writes frame size before frame data
// R4 - Frame data MSB first, whole words
// R5 - Device flags transmit ready at frame end
// R6 - Frame header fields fixed, reserved zero
// R7 - Egress capture select picks timestamp slot
// R8 - Host zeroes priority and timestamp bits
// R9 - Device prefixes receive timestamp, odd parity
// R10 - Clear receive mask for frame interrupts
// R11 - Read size then frame, zero padded
// R12 - Reread ready flag, repeat while set
// R13 - Host enables transmit cut-through first
// R14 - Transmit starts at threshold, default one
// R15 - Feed above 10 Mbps, else underrun flag
// R16 - Device discards CRC-errored register writes
// R17 - Host clears FIFO or rewrites after error
// R18 - Size rewrite with data outstanding is error
// R19 - Chunk payload 8 to 64, fixed after reset
// R20 - Equal transmit and receive chunks
// R21 - Select released between data and control
// R22 - Header leads transmit, footer trails receive
// R23 - Frames start on word boundaries
// R24 - Transmit header bit layout
// R25 - Invalid chunk payload ignored
// R26 - Odd parity over chunk header
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "mps_map.svh"
module mps_host_ctrl #(
  parameter int DEPTH = 512,
  parameter int DIV = 4,
  parameter int GAP = 8
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  localparam int AW = $clog2(DEPTH);
  localparam int IW = AW + 1;

  // Chunk header: fixed one at the top, reserved cleared, odd parity in bit 0
  function automatic logic [31:0] hdr_build(input logic [31:0] h);
    logic [31:0] b;
    b = (h & `MPS_HDR_MASK) | `MPS_HDR_ONE; // R24
    return {b[31:1], ~^b[31:1]}; // R26
  endfunction : hdr_build

  function automatic logic is_op(input mps_pkg::mps_op_t o, input mps_pkg::mps_op_t ref_op);
    return o == ref_op;
  endfunction : is_op

  mps_pkg::mps_state_t state_q, state_d;
  mps_pkg::mps_op_t op_q;
  logic [12:0] addr_q;
  logic [31:0] wdata_q, hdr_q, foot_q, rres_q, rdata_q;
  logic [IW-1:0] count_q, idx_q;
  logic [1:0] cfg_q;
  logic cfg_lock_q, done_q, cs_n_q;
  logic [AW-1:0] ptr_q;
  logic [7:0] gap_q;
  logic shift_done;
  logic [31:0] rx_word, buf_dout;

  wire idle = state_q == mps_pkg::ST_IDLE;
  wire wr_ok = reg_wr && idle;
  wire wr_cmd = wr_ok && (reg_addr == `MPS_OFF_CMD);
  wire [2:0] new_op = reg_wdata[2:0];
  wire op_valid = (new_op >= `MPS_OP_CWR) && (new_op <= `MPS_OP_CHUNK);
  wire start_cmd = wr_cmd && op_valid;
  wire op_cwr = is_op(op_q, `MPS_OP_CWR);
  wire op_crd = is_op(op_q, `MPS_OP_CRD);
  wire op_dwr = is_op(op_q, `MPS_OP_DWR);
  wire op_drd = is_op(op_q, `MPS_OP_DRD);
  wire op_chunk = is_op(op_q, `MPS_OP_CHUNK);

  // Words in one selection: command word plus data, or header plus payload
  wire [IW-1:0] chunk_w = IW'(2) << cfg_q; // R19
  wire [IW-1:0] last_idx = (op_cwr || op_crd) ? IW'(1) : op_chunk ? chunk_w : count_q; // R20
  wire at_last = idx_q == last_idx;
  wire idx0 = idx_q == '0;

  // First word: command with address, or the chunk header
  wire rw_bit = op_cwr || op_dwr;
  wire [31:0] cmd_word = {1'b1, 1'b0, rw_bit, addr_q, 16'h0000};
  wire [31:0] w0 = op_chunk ? hdr_build(hdr_q) : cmd_word; // R22
  // Frame header word has reserved, priority and timestamp bits cleared
  wire [31:0] buf_tx = (op_dwr && (idx_q == IW'(1))) ? (buf_dout & `MPS_FHDR_MASK) : buf_dout; // R6 R8
  wire [31:0] chunk_tx = hdr_q[`MPS_HDR_DV] ? buf_dout : 32'h0000_0000; // R23 R25
  wire [31:0] wn = op_cwr ? wdata_q : op_dwr ? buf_tx : op_chunk ? chunk_tx : 32'h0000_0000;
  wire [31:0] tx_sel = idx0 ? w0 : wn; // R4
  wire ta_op = op_crd || op_drd;
  wire [5:0] nb_sel = (!idx0 || op_chunk) ? `MPS_NB_WORD : ta_op ? `MPS_NB_TA : `MPS_NB_CMD;
  wire shift_start = state_q == mps_pkg::ST_LOAD;

  // Buffer port sharing: engine while busy, software while idle
  wire in_store = state_q == mps_pkg::ST_STORE;
  wire eng_we = in_store && ((op_drd && !idx0) || (op_chunk && !at_last)); // R11
  wire [IW-1:0] idx_m1 = idx_q - IW'(1);
  wire [AW-1:0] eng_wa = op_drd ? idx_m1[AW-1:0] : idx_q[AW-1:0];
  wire buf_hit = reg_addr == `MPS_OFF_BUF;
  wire sw_buf_wr = wr_ok && buf_hit;
  wire buf_acc = idle && (reg_wr || reg_rd) && buf_hit;
  wire wr_ptr = wr_ok && (reg_addr == `MPS_OFF_PTR);
  wire [AW-1:0] ptr_d = wr_ptr ? reg_wdata[AW-1:0] : buf_acc ? ptr_q + AW'(1) : ptr_q;
  wire mem_we = idle ? sw_buf_wr : eng_we;
  wire [AW-1:0] mem_wa = idle ? ptr_q : eng_wa;
  wire [31:0] mem_wd = idle ? reg_wdata : rx_word;
  wire [AW-1:0] mem_ra = idle ? ptr_d : idx_q[AW-1:0];

  wire gap_end = (state_q == mps_pkg::ST_GAP) && (gap_q == 8'h00);
  wire st_rd = reg_rd && (reg_addr == `MPS_OFF_STATUS);
  wire [31:0] status_w = {28'h000_0000, ^foot_q, cfg_lock_q, done_q, !idle};

  // Software read selection
  wire [31:0] rd_mux =
    (reg_addr == `MPS_OFF_ADDR) ? {19'h0, addr_q} :
    (reg_addr == `MPS_OFF_WDATA) ? wdata_q :
    (reg_addr == `MPS_OFF_COUNT) ? 32'(count_q) :
    (reg_addr == `MPS_OFF_HDR) ? hdr_q :
    (reg_addr == `MPS_OFF_STATUS) ? status_w :
    (reg_addr == `MPS_OFF_PTR) ? 32'(ptr_q) :
    (reg_addr == `MPS_OFF_BUF) ? buf_dout :
    (reg_addr == `MPS_OFF_CFG) ? {30'h0, cfg_q} :
    (reg_addr == `MPS_OFF_FOOT) ? foot_q :
    (reg_addr == `MPS_OFF_RDATA) ? rres_q : 32'h0000_0000;

  mps_buf_mem #(.W(32), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr(mem_ra),
    .rdata(buf_dout)
  );

  // Link rate is sys_clk over 2*DIV; below 10 Mbps keep transmit cut-through off
  mps_spi_shift #(.DIV(DIV)) u_shift ( // R15
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(shift_start),
    .tx_word(tx_sel),
    .nbits(nb_sel),
    .miso(spi_miso),
    .sclk(spi_sclk),
    .mosi(spi_mosi),
    .done(shift_done),
    .rx_word(rx_word)
  );

  // Transaction sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      mps_pkg::ST_IDLE:
      begin
        if (start_cmd)
        begin
          state_d = mps_pkg::ST_LOAD;
        end
      end
      mps_pkg::ST_LOAD:
      begin
        state_d = mps_pkg::ST_SHIFT;
      end
      mps_pkg::ST_SHIFT:
      begin
        if (shift_done)
        begin
          state_d = mps_pkg::ST_STORE;
        end
      end
      mps_pkg::ST_STORE:
      begin
        state_d = at_last ? mps_pkg::ST_GAP : mps_pkg::ST_LOAD;
      end
      mps_pkg::ST_GAP:
      begin
        if (gap_q == 8'h00)
        begin
          state_d = mps_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_d = mps_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= mps_pkg::ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Word index within the selection
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_q <= '0;
    end
    else if (start_cmd)
    begin
      idx_q <= '0;
    end
    else if (in_store && !at_last)
    begin
      idx_q <= idx_q + IW'(1);
    end
  end

  // Select low for one transaction only, then held high for the gap
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_n_q <= 1'b1;
      gap_q <= 8'h00;
    end
    else if (start_cmd)
    begin
      cs_n_q <= 1'b0;
    end
    else if (in_store && at_last)
    begin
      cs_n_q <= 1'b1; // R21
      gap_q <= 8'(GAP);
    end
    else if (state_q == mps_pkg::ST_GAP && gap_q != 8'h00)
    begin
      gap_q <= gap_q - 8'h01;
    end
  end

  // Command registers, writable only while idle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op_q <= `MPS_OP_CWR;
      addr_q <= 13'h0000;
      wdata_q <= 32'h0000_0000;
      count_q <= '0;
      hdr_q <= 32'h0000_0000;
    end
    else
    begin
      if (start_cmd)
      begin
        op_q <= new_op;
      end
      if (wr_ok && reg_addr == `MPS_OFF_ADDR)
      begin
        addr_q <= reg_wdata[12:0];
      end
      if (wr_ok && reg_addr == `MPS_OFF_WDATA)
      begin
        wdata_q <= reg_wdata; // R3 R10 R13 R17
      end
      if (wr_ok && reg_addr == `MPS_OFF_COUNT)
      begin
        count_q <= reg_wdata[IW-1:0]; // R18
      end
      if (wr_ok && reg_addr == `MPS_OFF_HDR)
      begin
        hdr_q <= reg_wdata;
      end
    end
  end

  // Payload size locked by the first chunk until reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q <= `MPS_CFG_RST;
      cfg_lock_q <= 1'b0;
    end
    else
    begin
      if (wr_ok && !cfg_lock_q && reg_addr == `MPS_OFF_CFG)
      begin
        cfg_q <= reg_wdata[1:0]; // R19
      end
      if (start_cmd && new_op == `MPS_OP_CHUNK)
      begin
        cfg_lock_q <= 1'b1; // R19
      end
    end
  end

  // Captured answers: register read result and receive footer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rres_q <= 32'h0000_0000;
      foot_q <= 32'h0000_0000;
    end
    else if (in_store && at_last)
    begin
      if (op_crd)
      begin
        rres_q <= rx_word; // R2 R12
      end
      if (op_chunk)
      begin
        foot_q <= rx_word; // R22
      end
    end
  end

  // Done is sticky; completion wins over a status read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= gap_end || (done_q && !st_rd && !start_cmd);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr_q <= '0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ptr_q <= ptr_d;
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign spi_cs_n = cs_n_q;
  assign reg_rdata = rdata_q;
endmodule : mps_host_ctrl

// ===== common/mps_map.svh
// Register offsets, field masks, reset values and op codes of the SPI host controller
// Assumes inclusion by bare name from the controller and the bench
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH
`define MPS_OFF_CMD 8'h00
`define MPS_OFF_ADDR 8'h04
`define MPS_OFF_WDATA 8'h08
`define MPS_OFF_COUNT 8'h0c
`define MPS_OFF_HDR 8'h10
`define MPS_OFF_STATUS 8'h14
`define MPS_OFF_PTR 8'h18
`define MPS_OFF_BUF 8'h1c
`define MPS_OFF_CFG 8'h20
`define MPS_OFF_FOOT 8'h24
`define MPS_OFF_RDATA 8'h28
`define MPS_OP_CWR 3'h1
`define MPS_OP_CRD 3'h2
`define MPS_OP_DWR 3'h3
`define MPS_OP_DRD 3'h4
`define MPS_OP_CHUNK 3'h5
`define MPS_CFG_RST 2'h3
`define MPS_HDR_MASK 32'h60ff_7fc0
`define MPS_HDR_ONE 32'h8000_0000
`define MPS_HDR_DV 21
`define MPS_FHDR_MASK 32'h00c0_ffff
`define MPS_NB_CMD 6'h10
`define MPS_NB_TA 6'h18
`define MPS_NB_WORD 6'h20
`define MPS_ST_BUSY 0
`define MPS_ST_DONE 1
`define MPS_ST_LOCK 2
`define MPS_ST_FOOT_OK 3
`endif

// ===== common/mps_pkg.sv
// Types shared by the SPI host controller modules
// Assumes mps_map.svh for all numeric constants
package mps_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_STORE, ST_GAP} mps_state_t;
  typedef logic [2:0] mps_op_t;
endpackage : mps_pkg

// ===== rtl/mps_buf_mem.sv
// Frame word buffer, one write port and one registered read port
// Assumes a single clock; a read in the cycle of a write to the same word returns the old word
`timescale 1ns/100ps
module mps_buf_mem #(
  parameter int W = 32,
  parameter int DEPTH = 512,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rdata_q;

  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

  assign rdata = rdata_q;
endmodule : mps_buf_mem

// ===== rtl/mps_spi_shift.sv
// SPI mode 0 word shifter: MSB first, clock divided from sys_clk
// Assumes DIV of at least 2 so the synchronised input settles before sampling
`timescale 1ns/100ps
module mps_spi_shift #(
  parameter int DIV = 4
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [31:0] tx_word,
  input wire logic [5:0] nbits,
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic done,
  output logic [31:0] rx_word
);
  localparam int DW = $clog2(DIV + 1);
  logic miso_m_q, miso_s_q;
  logic [31:0] sh_q, rx_q;
  logic [5:0] cnt_q;
  logic [DW-1:0] div_q;
  logic sclk_q, mosi_q, act_q, done_q;
  wire half = act_q && (div_q == DW'(DIV - 1));
  wire fall = half && sclk_q;

  // Two-stage synchroniser
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end
    else
    begin
      miso_m_q <= miso;
      miso_s_q <= miso_m_q;
    end
  end

  // Half-period divider and clock level
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q <= '0;
      sclk_q <= 1'b0;
    end
    else if (start || half)
    begin
      div_q <= '0;
      sclk_q <= !start && !sclk_q;
    end
    else if (act_q)
    begin
      div_q <= div_q + DW'(1);
    end
  end

  // Data changes on the falling edge, input sampled there too
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_q <= 32'h0000_0000;
      rx_q <= 32'h0000_0000;
      mosi_q <= 1'b0;
      cnt_q <= 6'h00;
      act_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= fall && (cnt_q == 6'h01);
      if (start)
      begin
        sh_q <= tx_word;
        mosi_q <= tx_word[31];
        cnt_q <= nbits;
        act_q <= 1'b1;
      end
      else if (fall)
      begin
        rx_q <= {rx_q[30:0], miso_s_q};
        sh_q <= {sh_q[30:0], 1'b0};
        mosi_q <= sh_q[30];
        cnt_q <= cnt_q - 6'h01;
        act_q <= cnt_q != 6'h01;
      end
    end
  end

  assign sclk = sclk_q;
  assign mosi = mosi_q;
  assign done = done_q;
  assign rx_word = rx_q;
endmodule : mps_spi_shift

// ===== dv/mps_host_ctrl_asserts.sv
// Port checks for the SPI host controller
// Assumes binding to mps_host_ctrl with its default DIV and GAP
`timescale 1ns/100ps
module mps_host_ctrl_asserts #(
  parameter int DIV = 4,
  parameter int GAP = 8
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_sclk_idle; spi_cs_n |-> !spi_sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock runs without select");
  property p_gap; $rose(spi_cs_n) |-> spi_cs_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
  property p_mosi_hold; spi_sclk |-> $stable(spi_mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
  property p_sclk_high; $rose(spi_sclk) |-> spi_sclk [*4] ##1 !spi_sclk; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("clock high time wrong");
  property p_sel_cause;
    $fell(spi_cs_n) |-> $past(reg_wr && reg_addr == 8'h00) || $past(reg_wr && reg_addr == 8'h00, 2);
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select without command");
  property p_first_bit; $fell(spi_cs_n) |-> ##1 spi_mosi; endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit not one");
  property p_load; $fell(spi_cs_n) |-> !spi_sclk [*5] ##1 spi_sclk; endproperty
  a_load: assert property (p_load) else $error("first clock edge misplaced");
  c_sel: cover property ($fell(spi_cs_n));
  c_end: cover property ($rose(spi_cs_n));
  c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : mps_host_ctrl_asserts

bind mps_host_ctrl mps_host_ctrl_asserts #(.DIV(DIV), .GAP(GAP)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

// ===== dv/mps_dev_model.sv
// Behavioural MAC-PHY on the SPI pins: register words, bursts and chunk exchange
// Assumes mode 0 and NW payload words per chunk
`timescale 1ns/100ps
module mps_dev_model #(
  parameter int NW = 2
)
(
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic chunk_mode,
  output logic spi_miso
);
  logic [31:0] mem [0:15];
  logic [31:0] sr;
  logic [31:0] osr;
  logic [31:0] hdr;
  logic [3:0] ptr;
  logic is_wr;
  logic hdr_bad;
  logic [1:0] egress;
  logic tx_rdy = 1'b0;
  int tx_bytes = 0;
  int bc;
  int n_dv = 0;
  initial spi_miso = 1'b0;
  always @(negedge spi_cs_n)
  begin
    bc = 0;
    osr = chunk_mode ? 32'h0a0b_0c00 : 32'h0;
    spi_miso = osr[31];
    osr = osr << 1;
  end
  // Released line shows the inverse of its last level
  always @(posedge spi_cs_n)
  begin
    spi_miso = ~spi_miso;
    if (!chunk_mode && is_wr && bc > 48)
    begin
      tx_rdy = 1'b1;
      tx_bytes = (bc - 16) / 8 + 2;
    end
  end
  always @(negedge spi_sclk)
  begin
    spi_miso = osr[31];
    osr = osr << 1;
  end
  always @(posedge spi_sclk)
  begin
    sr = {sr[30:0], spi_mosi};
    bc++;
    if (chunk_mode && bc % 32 == 0)
    begin
      if (bc == 32)
      begin
        hdr = sr;
        hdr_bad = ~^sr;
      end
      else if (hdr[21])
        n_dv++;
      osr = (bc / 32 < NW) ? 32'h0a0b_0c00 + 32'(bc / 32) : 32'h0000_0001;
    end
    else if (!chunk_mode && bc == 16)
    begin
      ptr = sr[3:0];
      is_wr = sr[13];
    end
    else if (!chunk_mode && is_wr && bc >= 48 && bc % 32 == 16)
    begin
      mem[ptr] = sr;
      if (bc == 48)
        egress = sr[23:22];
      ptr++;
    end
    else if (!chunk_mode && !is_wr && bc >= 24 && bc % 32 == 24)
    begin
      osr = mem[ptr];
      ptr++;
    end
  end
endmodule : mps_dev_model

// ===== dv/tb_mps_host_ctrl.sv
// Self-checking bench for the SPI host controller against a behavioural MAC-PHY
// Assumes the register map of mps_map.svh
`timescale 1ns/100ps
`include "mps_map.svh"
module tb_mps_host_ctrl;
  logic sys_clk, nrst, reg_wr, reg_rd, spi_sclk, spi_cs_n, spi_mosi, spi_miso, chunk_mode;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  int n_fail = 0;
  int comparisons = 0;
  logic [35:0] rows [4] = '{36'h3_1234_5678, 36'h5_8000_0001, 36'ha_ffff_ffff, 36'hf_0000_0000};
  mps_host_ctrl #(.DEPTH(16), .DIV(4), .GAP(8)) dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  mps_dev_model #(.NW(2)) dev (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .chunk_mode(chunk_mode), .spi_miso(spi_miso));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask : rdc
  task wt;
    int c;
    c = 0;
    repeat (2) @(posedge sys_clk);
    while (spi_cs_n !== 1'b1 && c < 5000)
    begin
      @(posedge sys_clk);
      c++;
    end
    if (c == 5000)
      n_fail++;
    repeat (12) @(posedge sys_clk);
  endtask : wt
  task go(input logic [2:0] op);
    wr(`MPS_OFF_CMD, {29'h0, op});
    wt();
  endtask : go
  initial
  begin
    #2000000;
    n_fail++;
    final_report();
  end
  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chunk_mode = 1'b0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc("cfg", `MPS_OFF_CFG, 32'h3);
    rdc("status", `MPS_OFF_STATUS, 32'h0);
    wr(8'hfc, 32'hffff_ffff);
    rdc("unmapped", 8'hfc, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`MPS_OFF_ADDR, {28'h0, rows[i][35:32]});
      wr(`MPS_OFF_WDATA, rows[i][31:0]);
      go(`MPS_OP_CWR);
      go(`MPS_OP_CRD);
      rdc("rdata", `MPS_OFF_RDATA, rows[i][31:0]);
    end
    $display("test table done");
    wr(`MPS_OFF_PTR, 32'h0);
    wr(`MPS_OFF_BUF, 32'hffc0_1122);
    wr(`MPS_OFF_BUF, 32'h3344_5566);
    wr(`MPS_OFF_ADDR, 32'h8);
    wr(`MPS_OFF_COUNT, 32'h2);
    go(`MPS_OP_DWR);
    go(`MPS_OP_DRD);
    wr(`MPS_OFF_PTR, 32'h0);
    rdc("frame header", `MPS_OFF_BUF, 32'h00c0_1122);
    rdc("frame word", `MPS_OFF_BUF, 32'h3344_5566);
    chk("egress select", 32'h3, dev.egress);
    chk("tx ready", 32'h1, dev.tx_rdy);
    chk("size field", 32'ha, dev.tx_bytes);
    $display("test burst done");
    chunk_mode <= 1'b1;
    wr(`MPS_OFF_CFG, 32'h0);
    wr(`MPS_OFF_PTR, 32'h0);
    wr(`MPS_OFF_BUF, 32'h1111_2222);
    wr(`MPS_OFF_BUF, 32'h3333_4444);
    wr(`MPS_OFF_HDR, 32'hffff_ffff);
    go(`MPS_OP_CHUNK);
    chk("header", 32'he0ff_7fc1, dev.hdr);
    chk("header parity", 32'h0, dev.hdr_bad);
    chk("valid words", 32'h2, dev.n_dv);
    rdc("status", `MPS_OFF_STATUS, 32'he);
    rdc("status clear", `MPS_OFF_STATUS, 32'hc);
    rdc("footer", `MPS_OFF_FOOT, 32'h1);
    wr(`MPS_OFF_PTR, 32'h0);
    rdc("rx word", `MPS_OFF_BUF, 32'h0a0b_0c00);
    wr(`MPS_OFF_CFG, 32'h3);
    rdc("cfg lock", `MPS_OFF_CFG, 32'h0);
    wr(`MPS_OFF_HDR, 32'h0);
    wr(`MPS_OFF_CMD, {29'h0, `MPS_OP_CHUNK});
    wr(`MPS_OFF_ADDR, 32'h5);
    wt();
    rdc("busy write", `MPS_OFF_ADDR, 32'h8);
    chk("header", 32'h8000_0000, dev.hdr);
    chk("valid words", 32'h2, dev.n_dv);
    chk("header parity", 32'h0, dev.hdr_bad);
    $display("test chunk done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc("cfg", `MPS_OFF_CFG, 32'h3);
    wr(`MPS_OFF_CFG, 32'h1);
    rdc("cfg", `MPS_OFF_CFG, 32'h1);
    wr(`MPS_OFF_CMD, 32'h6);
    rdc("bad op", `MPS_OFF_STATUS, 32'h0);
    chk("bad op select", 32'h1, spi_cs_n);
    $display("test reset again done");
    final_report();
  end
endmodule : tb_mps_host_ctrl
